//--- rtl/ctm_pkg.sv
/*
  shared constants and types of the composite timer: register map, field
  layout, function codes, noise filter modes, the per-timer run state and the per-channel pin group record.
  assumes a byte-wide register port with one-cycle read latency.
*/
package ctm_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // register indices (byte addresses on the plain port), channel 1 at +16
  localparam logic [ADDR_W-1:0] CH_STRIDE = 5'h10;
  localparam logic [3:0] OFS_CR0_LO = 4'h0;
  localparam logic [3:0] OFS_CR0_HI = 4'h1;
  localparam logic [3:0] OFS_CR1_LO = 4'h2;
  localparam logic [3:0] OFS_CR1_HI = 4'h3;
  localparam logic [3:0] OFS_DR_LO = 4'h4;
  localparam logic [3:0] OFS_DR_HI = 4'h5;
  localparam logic [3:0] OFS_MODE = 4'h6;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h7;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h8;

  // control register 0: [6:4] clock select, [3:0] function
  localparam int CR0_CLK_LSB = 4;
  localparam int CR0_FN_LSB = 0;
  // control register 1 bits
  localparam int CR1_STA = 7;
  localparam int CR1_IE = 5;
  localparam int CR1_SO = 1;
  localparam int CR1_OE = 0;
  // mode register: [7] cascade, [3:2] noise filter select, [1:0] output levels
  localparam int MODE_CASC = 7;
  localparam int MODE_NF_LSB = 2;
  localparam int MODE_OUT_HI = 1;
  localparam int MODE_OUT_LO = 0;

  localparam logic [7:0] CR_RESET = 8'h00;
  localparam logic [3:0] NF_TAPS = 4'h3;   // samples a level must hold

  // function codes
  localparam logic [3:0] FN_ONESHOT = 4'h0;
  localparam logic [3:0] FN_CONT = 4'h1;
  localparam logic [3:0] FN_FREERUN = 4'h2;
  localparam logic [3:0] FN_PWM_FIX = 4'h3;
  localparam logic [3:0] FN_PWM_VAR = 4'h4;
  localparam logic [3:0] FN_PWC = 4'h5;
  localparam logic [3:0] FN_CAP_CLR = 4'h6;
  localparam logic [3:0] FN_CAP_FREE = 4'h7;

  // noise filter modes
  localparam logic [1:0] NF_OFF = 2'h0;
  localparam logic [1:0] NF_HIGH = 2'h1;
  localparam logic [1:0] NF_LOW = 2'h2;
  localparam logic [1:0] NF_BOTH = 2'h3;

  // clock select: 0..5 prescaler taps, 6 time-base, 7 external input
  localparam logic [2:0] CLK_EXT = 3'h7;
  localparam int PRE_TAPS = 7;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_STOP} run_e;

  // outward pin group of one channel
  typedef struct packed {
    logic lo_out;
    logic lo_oe;
    logic hi_out;
    logic hi_oe;
  } pins_s;

endpackage

//--- rtl/ctm_noise_filter.sv
/*
  input noise filter for one channel's external input pin.
  assumes the pin is already synchronous to i_mclk.
*/
`timescale 1ns/1ps
module ctm_noise_filter
  import ctm_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // control and data
  input wire logic [1:0] i_mode,
  input wire logic i_pin,
  output logic o_level
);

  typedef struct packed {
    logic [3:0] cnt;
    logic level;
  } nf_s;

  nf_s s_q;
  nf_s s_d;

  // a change is accepted at once unless its direction is filtered;
  // a filtered change is accepted only after it holds NF_TAPS samples
  always_comb begin
    logic filt;
    filt = 1'b0;
    s_d = s_q;
    if (i_pin == s_q.level) begin
      s_d.cnt = 4'h0;
    end else begin
      filt = (i_mode == NF_BOTH) || (i_pin && i_mode == NF_HIGH) ||
             (!i_pin && i_mode == NF_LOW);
      if (!filt || s_q.cnt == NF_TAPS - 4'h1) begin
        s_d.level = i_pin;
        s_d.cnt = 4'h0;
      end else begin
        s_d.cnt = s_q.cnt + 4'h1;
      end
    end
  end

  // state register
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;

endmodule

//--- rtl/ctm_timer.sv
/*
  two-channel 8/16-bit composite timer with byte register port, level
  interrupt and timer output pins.
  assumes pins synchronous to i_mclk and a master that never waits.
*/
// Local design decisions: the placing of the registers and the plain strobed port.
// Notes on behaviour
// - each channel has two 8-bit counters, used alone or cascaded into 16 bits.
// - the comparator checks the counter against a latched copy of the data register.
// - data register writes set the top count; reads return captures in measure modes.
// - the input filter can reject high pulses, low pulses or both.
// - the count clock is one of several prescaler taps, time-base included.
// - a timer output reaches its pin only while that pin's output is enabled.
// - the first pin carries the lower or cascaded output and drives in timer and measure modes; the code drops its enable in the capture modes.
// - the first pin's level is undefined when enabled in capture mode.
// - the second pin carries the upper output and drives in interval or fixed PWM modes; the code drives it in 8-bit mode only, plus width measure on channel 1.
// - in 16-bit mode the second pin is undefined in variable PWM or capture.
// - one external input pin feeds both internal timer inputs of a channel.
// - the internal input clocks the counter in timer modes, is the signal in measure modes.
// - in 16-bit mode the upper internal input is unused except in variable PWM; the code ignores it there too, as the upper timer steps on the lower overflow.
// - both channels are identical replicas with their own pins and registers; in the code only channel 1 drives its upper pin in width measure.
// - one-shot counts from zero, and on match toggles output, interrupts and stops.
`timescale 1ns/1ps
module ctm_timer
  import ctm_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // prescaler taps and time-base output, one-cycle pulses
  input wire logic [PRE_TAPS-1:0] i_presc_tick,
  // external input pins
  input wire logic [CHANNELS-1:0] i_ext_input_pin,
  // timer output pins
  output logic [CHANNELS-1:0] o_lower_out_pin,
  output logic [CHANNELS-1:0] o_lower_out_oe,
  output logic [CHANNELS-1:0] o_upper_out_pin,
  output logic [CHANNELS-1:0] o_upper_out_oe,
  // interrupt
  output logic o_irq
);

  // the map has room for two channel blocks only
  if (CHANNELS < 1 || CHANNELS > 2) begin : g_chk
    $error("CHANNELS must be 1 or 2");
  end

  // per-timer state
  typedef struct packed {
    logic [7:0] cr0;
    logic [7:0] cr1;
    logic [7:0] dr;       // software-written top count
    logic [7:0] latch;    // comparator copy of dr
    logic [7:0] cnt;
    logic [7:0] cap;      // captured count
    logic out;
    logic in_q;
    run_e run;
  } tmr_s;

  typedef struct packed {
    tmr_s [1:0] t;
    logic [7:0] mode;
    logic [7:0] stat;
    logic [7:0] mask;
  } chan_s;

  typedef struct packed {
    chan_s [CHANNELS-1:0] c;
    logic [DATA_W-1:0] rdata;
  } state_s;

  state_s s_q;
  state_s s_d;
  logic [CHANNELS-1:0] filt_lvl;

  // function code helpers
  function automatic logic is_measure(input logic [3:0] fn);
    return fn == FN_PWC || fn == FN_CAP_CLR || fn == FN_CAP_FREE;
  endfunction

  // count clock selection: prescaler tap or external input edge
  function automatic logic pick_tick(input logic [2:0] sel, input logic [PRE_TAPS-1:0] pre,
                                     input logic ext_rise, input logic [3:0] fn);
    // measure modes never take the input as clock
    if (sel == CLK_EXT) begin
      return ext_rise && !is_measure(fn);
    end
    return pre[sel];
  endfunction

  // register block decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input int ch,
                               input logic [3:0] ofs);
    // channel blocks sit one stride apart
    return a == ADDR_W'(ch * CH_STRIDE) + ADDR_W'(ofs);
  endfunction

  // each channel filters its own pin
  for (genvar g = 0; g < CHANNELS; g++) begin : g_nf
    ctm_noise_filter u_nf (
      .i_mclk(i_mclk),
      .i_sys_rst(i_sys_rst),
      .i_mode(s_q.c[g].mode[MODE_NF_LSB +: 2]),
      .i_pin(i_ext_input_pin[g]),
      .o_level(filt_lvl[g])
    );
  end

  // next state for registers, counters, capture, outputs and interrupts
  always_comb begin
    logic casc;
    logic [3:0] fn;
    logic lvl;
    logic rise;
    logic fall;
    logic tick;
    logic lo_ovf;
    logic match;
    logic [7:0] ev;
    logic [15:0] c16;
    logic [15:0] top16;
    casc = 1'b0;
    fn = 4'h0;
    lvl = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    tick = 1'b0;
    lo_ovf = 1'b0;
    match = 1'b0;
    ev = 8'h00;
    c16 = 16'h0000;
    top16 = 16'h0000;
    // every field holds unless a rule below moves it
    s_d = s_q;
    // read data stands one cycle, zero otherwise
    s_d.rdata = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      casc = s_q.c[ch].mode[MODE_CASC];
      lvl = filt_lvl[ch];
      ev = 8'h00;
      lo_ovf = 1'b0;
      // timer 0 runs first, so its carry is known to timer 1
      // both internal inputs see the same filtered pin
      for (int k = 0; k < 2; k++) begin
        s_d.c[ch].t[k].in_q = lvl;
        rise = lvl && !s_q.c[ch].t[k].in_q;
        fall = !lvl && s_q.c[ch].t[k].in_q;
        // in cascade the lower timer's function governs the pair
        fn = (casc && k == 1) ? s_q.c[ch].t[0].cr0[CR0_FN_LSB +: 4]
                              : s_q.c[ch].t[k].cr0[CR0_FN_LSB +: 4];
        if (casc && k == 1 && fn != FN_PWM_VAR) begin
          rise = 1'b0;  // upper input unused in 16-bit mode
          fall = 1'b0;
        end
        tick = pick_tick(s_q.c[ch].t[k].cr0[CR0_CLK_LSB +: 3], i_presc_tick, rise, fn);
        if (casc && k == 1) begin
          tick = lo_ovf;  // upper steps on lower overflow
        end
        // stopped: clear count, preload output and compare copy
        if (!s_q.c[ch].t[k].cr1[CR1_STA]) begin
          s_d.c[ch].t[k].run = ST_IDLE;
          s_d.c[ch].t[k].cnt = 8'h00;
          s_d.c[ch].t[k].out = s_q.c[ch].t[k].cr1[CR1_SO];
          s_d.c[ch].t[k].latch = s_q.c[ch].t[k].dr;
        end else begin
          if (s_q.c[ch].t[k].run == ST_IDLE) begin
            s_d.c[ch].t[k].run = ST_RUN;  // starts from zero
          end
          // cascade compares the pair as one 16-bit value
          if (casc) begin
            c16 = {s_q.c[ch].t[1].cnt, s_q.c[ch].t[0].cnt};
            top16 = {s_q.c[ch].t[1].latch, s_q.c[ch].t[0].latch};
            match = c16 == top16;
          end else begin
            match = s_q.c[ch].t[k].cnt == s_q.c[ch].t[k].latch;
          end
          if (tick && s_q.c[ch].t[k].run == ST_RUN) begin
            case (fn)
              FN_ONESHOT, FN_CONT: begin
                if (match && (!casc || k == 0)) begin
                  s_d.c[ch].t[k].out = !s_q.c[ch].t[k].out;
                  ev[k] = 1'b1;
                  // a top written meanwhile applies from here on
                  s_d.c[ch].t[k].latch = s_q.c[ch].t[k].dr;
                  if (casc) begin
                    s_d.c[ch].t[1].cnt = 8'h00;
                    s_d.c[ch].t[1].latch = s_q.c[ch].t[1].dr;
                  end
                  s_d.c[ch].t[k].cnt = 8'h00;
                  if (fn == FN_ONESHOT) begin
                    s_d.c[ch].t[k].run = ST_STOP;
                    if (casc) begin
                      s_d.c[ch].t[1].run = ST_STOP;
                    end
                  end
                end else begin
                  s_d.c[ch].t[k].cnt = s_q.c[ch].t[k].cnt + 8'h01;
                  // carry out of the low byte
                  lo_ovf = k == 0 && s_q.c[ch].t[0].cnt == 8'hff;
                end
              end
              FN_FREERUN, FN_PWM_FIX, FN_PWM_VAR: begin
                if (match && (!casc || k == 0)) begin
                  s_d.c[ch].t[k].out = fn == FN_FREERUN ? !s_q.c[ch].t[k].out : 1'b0;
                  ev[k] = 1'b1;
                end
                if (fn != FN_FREERUN && s_q.c[ch].t[k].cnt == 8'hff && (!casc || k == 1)) begin
                  s_d.c[ch].t[k].out = 1'b1;  // new fixed cycle starts high
                  s_d.c[ch].t[k].latch = s_q.c[ch].t[k].dr;
                end
                s_d.c[ch].t[k].cnt = s_q.c[ch].t[k].cnt + 8'h01;
                lo_ovf = k == 0 && s_q.c[ch].t[0].cnt == 8'hff;
              end
              default: begin
                // measure modes count the prescaler, never the input edge
                s_d.c[ch].t[k].cnt = s_q.c[ch].t[k].cnt + 8'h01;
                lo_ovf = k == 0 && s_q.c[ch].t[0].cnt == 8'hff;
              end
            endcase
          end

          // measured-signal edges capture the count
          // width measure: rise restarts, fall captures
          if (is_measure(fn) && (!casc || k == 0)) begin
            if (fn == FN_PWC && rise) begin
              s_d.c[ch].t[k].cnt = 8'h00;
              if (casc) begin
                s_d.c[ch].t[1].cnt = 8'h00;
              end
              s_d.c[ch].t[k].out = 1'b1;
            end else if ((fn == FN_PWC && fall) || (fn != FN_PWC && rise)) begin
              s_d.c[ch].t[k].cap = s_q.c[ch].t[k].cnt;
              s_d.c[ch].t[1].cap = casc ? s_q.c[ch].t[1].cnt : s_d.c[ch].t[1].cap;
              ev[k] = 1'b1;
              s_d.c[ch].t[k].out = 1'b0;
              if (fn == FN_CAP_CLR) begin
                s_d.c[ch].t[k].cnt = 8'h00;
                if (casc) begin
                  s_d.c[ch].t[1].cnt = 8'h00;
                end
              end
            end
          end
        end
      end

      // sticky status; a new event wins over a write-one clear
      // the clear works on the old value, the event is or-ed after
      if (i_wr && hit(i_addr, ch, OFS_IRQ_STAT)) begin
        s_d.c[ch].stat = s_q.c[ch].stat & ~i_wdata;
      end
      s_d.c[ch].stat = s_d.c[ch].stat | ev;

      // register writes
      if (i_wr) begin
        if (hit(i_addr, ch, OFS_CR0_LO)) s_d.c[ch].t[0].cr0 = i_wdata;
        if (hit(i_addr, ch, OFS_CR0_HI)) s_d.c[ch].t[1].cr0 = i_wdata;
        if (hit(i_addr, ch, OFS_CR1_LO)) s_d.c[ch].t[0].cr1 = i_wdata;
        if (hit(i_addr, ch, OFS_CR1_HI)) s_d.c[ch].t[1].cr1 = i_wdata;
        if (hit(i_addr, ch, OFS_DR_LO)) s_d.c[ch].t[0].dr = i_wdata;
        if (hit(i_addr, ch, OFS_DR_HI)) s_d.c[ch].t[1].dr = i_wdata;
        if (hit(i_addr, ch, OFS_MODE)) s_d.c[ch].mode = i_wdata;
        if (hit(i_addr, ch, OFS_IRQ_MASK)) s_d.c[ch].mask = i_wdata;
      end

      // reads; data register returns capture in measure modes
      // in cascade both bytes follow the lower timer's function
      if (i_rd) begin
        for (int k = 0; k < 2; k++) begin
          fn = s_q.c[ch].t[casc ? 0 : k].cr0[CR0_FN_LSB +: 4];
          if (hit(i_addr, ch, k == 0 ? OFS_DR_LO : OFS_DR_HI)) begin
            s_d.rdata = is_measure(fn) ? s_q.c[ch].t[k].cap : s_q.c[ch].t[k].dr;
          end
        end
        if (hit(i_addr, ch, OFS_CR0_LO)) s_d.rdata = s_q.c[ch].t[0].cr0;
        if (hit(i_addr, ch, OFS_CR0_HI)) s_d.rdata = s_q.c[ch].t[1].cr0;
        if (hit(i_addr, ch, OFS_CR1_LO)) s_d.rdata = s_q.c[ch].t[0].cr1;
        if (hit(i_addr, ch, OFS_CR1_HI)) s_d.rdata = s_q.c[ch].t[1].cr1;
        if (hit(i_addr, ch, OFS_MODE)) begin
          s_d.rdata = {s_q.c[ch].mode[7:2], s_q.c[ch].t[1].out, s_q.c[ch].t[0].out};
        end
        if (hit(i_addr, ch, OFS_IRQ_STAT)) s_d.rdata = s_q.c[ch].stat;
        if (hit(i_addr, ch, OFS_IRQ_MASK)) s_d.rdata = s_q.c[ch].mask;
      end
    end
  end

  // state register
  // reset leaves pins undriven and the interrupt low
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // output controller: drive only while enabled and in a driving function
  always_comb begin
    logic casc;
    logic [3:0] fn0;
    logic [3:0] fn1;
    casc = 1'b0;
    fn0 = 4'h0;
    fn1 = 4'h0;
    o_irq = 1'b0;
    o_lower_out_pin = '0;
    o_lower_out_oe = '0;
    o_upper_out_pin = '0;
    o_upper_out_oe = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      casc = s_q.c[ch].mode[MODE_CASC];
      fn0 = s_q.c[ch].t[0].cr0[CR0_FN_LSB +: 4];
      fn1 = s_q.c[ch].t[1].cr0[CR0_FN_LSB +: 4];
      // an undefined level is avoided by dropping the enable
      // lower pin carries timer 0 or the pair; capture leaves it undriven
      o_lower_out_pin[ch] = s_q.c[ch].t[0].out;
      o_lower_out_oe[ch] = s_q.c[ch].t[0].cr1[CR1_OE] &&
                           (fn0 == FN_ONESHOT || fn0 == FN_CONT || fn0 == FN_FREERUN ||
                            fn0 == FN_PWM_FIX || fn0 == FN_PWM_VAR || fn0 == FN_PWC);
      // upper pin in 8-bit interval or fixed PWM modes, and in 8-bit width measure on channel 1 only
      o_upper_out_pin[ch] = s_q.c[ch].t[1].out;
      o_upper_out_oe[ch] = s_q.c[ch].t[1].cr1[CR1_OE] && !casc &&
                           (fn1 == FN_ONESHOT || fn1 == FN_CONT || fn1 == FN_FREERUN ||
                            fn1 == FN_PWM_FIX || (ch == 1 && fn1 == FN_PWC));
      // level interrupt: any unmasked sticky bit
      o_irq = o_irq || |(s_q.c[ch].stat & s_q.c[ch].mask);
    end
  end

  assign o_rdata = s_q.rdata;

endmodule

//--- sim/ctm_timer_chk.sv
/*
  port checker of the composite timer, bound into ctm_timer.
  assumes the ctm_pkg register map and a synchronous reset.
*/
`timescale 1ns/1ps
module ctm_timer_chk
  import ctm_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // ticks and pins
  input wire logic [PRE_TAPS-1:0] i_presc_tick,
  input wire logic [CHANNELS-1:0] i_ext_input_pin,
  input wire logic [CHANNELS-1:0] o_lower_out_pin,
  input wire logic [CHANNELS-1:0] o_lower_out_oe,
  input wire logic [CHANNELS-1:0] o_upper_out_pin,
  input wire logic [CHANNELS-1:0] o_upper_out_oe,
  input wire logic o_irq
);
  logic [CHANNELS-1:0] casc_q;
  logic [CHANNELS-1:0] ext_q;
  logic [2*CHANNELS-1:0] mask_q;
  logic [3:0] fn_q [CHANNELS];
  logic [3:0] quiet_q;
  logic [3:0] ofs;
  logic ch;

  // address split into offset and channel
  assign ofs = i_addr[3:0];
  assign ch = i_addr[4];

  // shadows of written fields and cycles since the last possible cause
  always_ff @(posedge i_mclk) begin
    ext_q <= i_ext_input_pin;
    if (i_sys_rst) begin
      casc_q <= '0;
      mask_q <= '0;
      fn_q <= '{default: 4'h0};
      quiet_q <= 4'h0;
    end else begin
      if (i_wr && ofs == OFS_MODE) begin
        casc_q[ch] <= i_wdata[MODE_CASC];
      end
      if (i_wr && ofs == OFS_IRQ_MASK) begin
        mask_q[{ch, 1'b0} +: 2] <= i_wdata[1:0];
      end
      if (i_wr && ofs == OFS_CR0_LO) begin
        fn_q[ch] <= i_wdata[3:0];
      end
      if (i_wr || (|i_presc_tick) || ext_q != i_ext_input_pin) begin
        quiet_q <= 4'h0;
      end else if (quiet_q != 4'hf) begin
        quiet_q <= quiet_q + 4'h1;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_reset_quiet: assert property ($fell(i_sys_rst) |->
    !o_irq && o_lower_out_oe == '0 && o_upper_out_oe == '0)
    else $error("outputs active after reset");
  a_oe_by_write: assert property (((o_lower_out_oe & ~$past(o_lower_out_oe)) |
    (o_upper_out_oe & ~$past(o_upper_out_oe))) != '0 |-> $past(i_wr))
    else $error("pin enable rose without a write");
  a_casc_upper_off: assert property ((casc_q & o_upper_out_oe) == '0)
    else $error("upper pin driven while cascaded");
  a_irq_needs_mask: assert property (o_irq |-> mask_q != '0)
    else $error("interrupt with every source masked");
  a_irq_sticky: assert property ($fell(o_irq) && !$past(i_sys_rst) |-> $past(i_wr))
    else $error("interrupt dropped without a write");
  a_pin_has_cause: assert property (
    $changed({o_lower_out_pin, o_upper_out_pin}) |-> quiet_q < 4'h8)
    else $error("pin level moved with no tick, edge or write");
  a_cap_lower_off0: assert property (fn_q[0][3:1] == 3'h3 |-> !o_lower_out_oe[0])
    else $error("lower pin driven in capture on channel 0");
  a_cap_lower_off1: assert property (fn_q[1][3:1] == 3'h3 |-> !o_lower_out_oe[1])
    else $error("lower pin driven in capture on channel 1");

  c_irq: cover property ($rose(o_irq));
  c_upper_oe: cover property ($rose(|o_upper_out_oe));
  c_lower_toggle: cover property ($changed(o_lower_out_pin) && o_lower_out_oe != '0);
endmodule

bind ctm_timer ctm_timer_chk #(.CHANNELS(CHANNELS)) chk_u (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_presc_tick(i_presc_tick),
  .i_ext_input_pin(i_ext_input_pin), .o_lower_out_pin(o_lower_out_pin),
  .o_lower_out_oe(o_lower_out_oe), .o_upper_out_pin(o_upper_out_pin),
  .o_upper_out_oe(o_upper_out_oe), .o_irq(o_irq)
);

//--- sim/ctm_pin_partner.sv
/*
  far side of the timer: prescaler taps and pulse sources on the input pins.
  assumes the bench calls pulse() from one process at a time.
*/
`timescale 1ns/1ps
module ctm_pin_partner
  import ctm_pkg::*;
#(
  parameter int CHANNELS = 2
) (
  // clock
  input wire logic i_mclk,
  // taps and input pins
  output logic [PRE_TAPS-1:0] o_presc_tick,
  output logic [CHANNELS-1:0] o_ext_pin
);
  int cyc = 0;

  // pins idle low, taps quiet at time zero
  initial begin
    o_ext_pin = '0;
    o_presc_tick = '0;
  end

  // tap k pulses once every 2*(k+1) cycles, the top tap acts as time-base
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    for (int k = 0; k < PRE_TAPS; k++) begin
      o_presc_tick[k] <= (cyc % (2 * (k + 1))) == 0;
    end
  end

  // high pulse of hi cycles, then lo cycles low; the pin is only ever an input
  task automatic pulse(input int ch, input int hi, input int lo);
    @(posedge i_mclk);
    o_ext_pin[ch] <= 1'b1;
    repeat (hi) @(posedge i_mclk);
    o_ext_pin[ch] <= 1'b0;
    repeat (lo) @(posedge i_mclk);
  endtask
endmodule

//--- sim/tb_top.sv
/*
  self-checking bench of the composite timer: registers, pin enables,
  one-shot timing on every tap, cascade and the shared input pin.
  assumes the bound checker and ctm_pin_partner for taps and pins.
*/
`timescale 1ns/1ps
module tb_top
  import ctm_pkg::*;
;
  logic i_mclk, i_sys_rst, i_wr, i_rd, o_irq;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [PRE_TAPS-1:0] tick;
  logic [1:0] ext, lo_pin, lo_oe, hi_pin, hi_oe;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;

  ctm_timer #(.CHANNELS(2)) dut_u (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_presc_tick(tick),
    .i_ext_input_pin(ext), .o_lower_out_pin(lo_pin), .o_lower_out_oe(lo_oe),
    .o_upper_out_pin(hi_pin), .o_upper_out_oe(hi_oe), .o_irq(o_irq)
  );
  ctm_pin_partner #(.CHANNELS(2)) part_u (.i_mclk(i_mclk), .o_presc_tick(tick), .o_ext_pin(ext));

  // verdict and end of run
  task automatic close_out;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [ADDR_W-1:0] ad(input int ch, input logic [3:0] o);
    return {ch[0], o};
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (o_irq !== 1'b1 && n < lim) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
  endtask

  // stop, clear, configure and start one channel
  task automatic arm(input int ch, input logic [7:0] c0, dl, dh, md, input logic hi_run);
    wr(ad(ch, OFS_CR1_LO), 8'h00);
    wr(ad(ch, OFS_CR1_HI), 8'h00);
    wr(ad(ch, OFS_IRQ_STAT), 8'h03);
    wr(ad(ch, OFS_MODE), md);
    wr(ad(ch, OFS_CR0_LO), c0);
    wr(ad(ch, OFS_CR0_HI), c0);
    wr(ad(ch, OFS_DR_LO), dl);
    wr(ad(ch, OFS_DR_HI), dh);
    wr(ad(ch, OFS_IRQ_MASK), 8'h03);
    wr(ad(ch, OFS_CR1_HI), {hi_run, 7'h01});
    wr(ad(ch, OFS_CR1_LO), 8'h81);
  endtask

  task automatic t_reset;
    chk({3'h0, o_irq, lo_oe, hi_oe}, 8'h00);
    rd_chk(ad(0, OFS_CR0_LO), CR_RESET);
    rd_chk(ad(1, OFS_MODE), 8'h00);
    wr(5'h0b, 8'hff);
    rd_chk(5'h0b, 8'h00);
  endtask

  task automatic t_dr;
    wr(ad(0, OFS_DR_LO), 8'h5a);
    wr(ad(0, OFS_DR_HI), 8'ha5);
    wr(ad(1, OFS_DR_LO), 8'h3c);
    rd_chk(ad(0, OFS_DR_LO), 8'h5a);
    rd_chk(ad(0, OFS_DR_HI), 8'ha5);
    rd_chk(ad(1, OFS_DR_LO), 8'h3c);
  endtask

  // every function, both widths, both channels: which pin may drive
  task automatic t_oe;
    for (int ch = 0; ch < 2; ch++) begin
      for (int c = 0; c < 2; c++) begin
        for (int f = 0; f < 8; f++) begin
          wr(ad(ch, OFS_MODE), {c[0], 7'h00});
          wr(ad(ch, OFS_CR0_LO), {4'h0, f[3:0]});
          wr(ad(ch, OFS_CR0_HI), {4'h0, f[3:0]});
          wr(ad(ch, OFS_CR1_LO), 8'h01);
          wr(ad(ch, OFS_CR1_HI), 8'h01);
          #1;
          chk({7'h0, lo_oe[ch]}, {7'h0, f < 6});
          chk({7'h0, hi_oe[ch]}, {7'h0, c == 0 && (f < 4 || (f == 5 && ch == 1))});
        end
      end
      wr(ad(ch, OFS_CR1_LO), 8'h00);
      wr(ad(ch, OFS_CR1_HI), 8'h00);
      wr(ad(ch, OFS_CR0_LO), 8'h00);
      wr(ad(ch, OFS_CR0_HI), 8'h00);
      wr(ad(ch, OFS_MODE), 8'h00);
    end
    #1;
    chk({4'h0, lo_oe, hi_oe}, 8'h00);
  endtask

  // one-shot with a top of 2 (fires on the third tick) on each tap, then stop, mask and clear
  task automatic t_taps;
    for (int k = 0; k < PRE_TAPS; k++) begin
      arm(0, {1'b0, k[2:0], FN_ONESHOT}, 8'h02, 8'h00, 8'h00, 1'b0);
      wait_irq(200);
      chk({7'h0, n >= 2 * (k + 1) && n <= 6 * (k + 1) + 4}, 8'h01);
      chk({7'h0, lo_pin[0]}, 8'h01);
    end
    repeat (40) @(posedge i_mclk);
    #1;
    chk({6'h0, o_irq, lo_pin[0]}, 8'h03);
    rd_chk(ad(0, OFS_IRQ_STAT), 8'h01);
    wr(ad(0, OFS_IRQ_MASK), 8'h00);
    #1;
    chk({7'h0, o_irq}, 8'h00);
    wr(ad(0, OFS_IRQ_MASK), 8'h01);
    #1;
    chk({7'h0, o_irq}, 8'h01);
    wr(ad(0, OFS_IRQ_STAT), 8'h01);
    #1;
    chk({7'h0, o_irq}, 8'h00);
    repeat (40) @(posedge i_mclk);
    rd_chk(ad(0, OFS_IRQ_STAT), 8'h00);
  endtask

  // 16-bit top of 0102 on the fastest tap
  task automatic t_casc;
    arm(0, 8'h00, 8'h02, 8'h01, 8'h80, 1'b1);
    wait_irq(1000);
    chk({7'h0, n >= 514 && n <= 522}, 8'h01);
    arm(0, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0);
    wr(ad(0, OFS_CR1_LO), 8'h00);
    wr(ad(0, OFS_IRQ_STAT), 8'h03);
  endtask

  // shared input pin clocks both timers of channel 1, glitches filtered
  task automatic t_ext;
    arm(0, {1'b0, CLK_EXT, FN_ONESHOT}, 8'h02, 8'h02, 8'h04, 1'b1);
    arm(1, {1'b0, CLK_EXT, FN_ONESHOT}, 8'h02, 8'h02, 8'h04, 1'b1);
    repeat (3) part_u.pulse(1, 1, 5);
    #1;
    chk({7'h0, o_irq}, 8'h00);
    repeat (3) part_u.pulse(1, 6, 6);
    wait_irq(20);
    chk({6'h0, hi_pin[1], lo_pin[1]}, 8'h03);
    rd_chk(ad(1, OFS_IRQ_STAT), 8'h03);
    rd_chk(ad(0, OFS_IRQ_STAT), 8'h00);
  endtask

  // a 21-cycle pulse measured on channel 1 at tap 0: ten ticks between edges
  task automatic t_pwc;
    arm(1, {4'h0, FN_PWC}, 8'h00, 8'h00, 8'h00, 1'b0);
    part_u.pulse(1, 21, 4);
    rd_chk(ad(1, OFS_DR_LO), 8'h0a);
    rd_chk(ad(1, OFS_IRQ_STAT), 8'h01);
  endtask

  // clock of 8 ns
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end

  // main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = '0;
    i_wdata = '0;
    repeat (10) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_dr();
    t_oe();
    t_taps();
    t_casc();
    t_ext();
    t_pwc();
    close_out();
  end

  // hang guard
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      close_out();
    end
  end
endmodule
